//--- itd_defines.vh
// constants for the serial-bus target address and data engine
// assumes inclusion by itd_target.v and the assertion module; definitions only, no logic
`ifndef ITD_DEFINES_VH
`define ITD_DEFINES_VH

// slave_command value that acts on the current direction
`define ITD_CMD_ACK_ACTION 2'h3
// bits in one address or data byte
`define ITD_BYTE_BITS      4'h8
// first clock of the acknowledge slot
`define ITD_ACK_SEEN       4'h1
// counter clear value
`define ITD_CNT_ZERO       4'h0
// acknowledge action encoding: 0 drives the data line low
`define ITD_ACK            1'b0
`define ITD_NACK           1'b1
// direction bit of the address byte
`define ITD_DIR_READ       1'b1
// reset values
`define ITD_BYTE_RST       8'h00
`define ITD_ADDR_RST       7'h00
// acknowledge slot phase
`define ITD_PH_ADDR        1'b0
`define ITD_PH_DATA        1'b1

`endif

//--- itd_target.v
// target-side engine of a two-wire serial bus: start/stop, address match,
// clock stretching, acknowledge, data in and out, collision and flags.
// assumes scl_in/sda_in come from pins; wire level = low when any *_oe is high.
`timescale 1ns/100ps
`include "itd_defines.vh"

module itd_target (
  // clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // serial bus pins, open drain
  input  wire       scl_in,
  output reg        scl_out_r,
  output reg        scl_oe_r,
  input  wire       sda_in,
  output reg        sda_out_r,
  output reg        sda_oe_r,
  // configuration
  input  wire       enable,
  input  wire       smart_mode_en,
  input  wire       stretch_after_ack_mode,
  input  wire       ack_action,
  input  wire [6:0] own_addr,
  // software strobes
  input  wire       addr_match_clr,
  input  wire       stop_clr,
  input  wire       coll_clr,
  input  wire       slave_command_wr,
  input  wire [1:0] slave_command,
  // transmit data, one byte per handshake
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output reg        tx_ready_r,
  // received data out of the two-entry buffer
  output reg  [7:0] rx_data_r,
  output reg        rx_valid_r,
  input  wire       rx_ready,
  // status
  output reg        addr_match_flag_r,
  output reg        data_ready_flag_r,
  output reg        stop_received_flag_r,
  output reg        collision_seen_r,
  output reg        dir_r,
  output reg        busy_r
);

  localparam [10:0] S_IDLE  = 11'h001;
  localparam [10:0] S_ADDR  = 11'h002;
  localparam [10:0] S_AHOLD = 11'h004;
  localparam [10:0] S_ACK   = 11'h008;
  localparam [10:0] S_POST  = 11'h010;
  localparam [10:0] S_RXD   = 11'h020;
  localparam [10:0] S_RPUSH = 11'h040;
  localparam [10:0] S_RHOLD = 11'h080;
  localparam [10:0] S_TXW   = 11'h100;
  localparam [10:0] S_TXD   = 11'h200;
  localparam [10:0] S_TXACK = 11'h400;

  // both pin synchronisers: stage 1 feeds only stage 2
  reg  [1:0] sync1_r;
  reg  [1:0] sync2_r;
  reg  [1:0] prev_r;
  wire [1:0] pin_in;
  assign pin_in = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      always @(posedge clock) begin
        if (!rst_b) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
          prev_r[gi]  <= 1'b1;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi]  <= sync2_r[gi];
        end
      end
    end
  endgenerate

  function addr_hit;
    input [7:0] rx;
    input [6:0] mine;
    begin
      addr_hit = (rx[7:1] == mine);
    end
  endfunction

  wire scl_s    = sync2_r[0];
  wire sda_s    = sync2_r[1];
  wire scl_rise = scl_s & ~prev_r[0];
  wire scl_fall = ~scl_s & prev_r[0];
  wire start_c  = scl_s & prev_r[0] & ~sda_s & prev_r[1];
  wire stop_c   = scl_s & prev_r[0] & sda_s & ~prev_r[1];

  reg [10:0] state_r;
  reg  [3:0] cnt_r;
  reg  [7:0] sh_r;
  reg        ack_bit_r;
  reg        phase_r;
  reg        mode_r;
  reg  [7:0] e1_data_r;
  reg        e1_valid_r;

  wire cmd3     = slave_command_wr & (slave_command == `ITD_CMD_ACK_ACTION);
  wire rx_pop   = rx_valid_r & rx_ready;
  wire smart_rd = smart_mode_en & rx_pop;
  wire rx_room  = ~e1_valid_r;
  wire tx_take  = tx_valid & tx_ready_r;

  // flag events computed by the bus engine below
  reg set_am;
  reg set_dr;
  // combinational so the hold state and the flag see the clear in one cycle
  wire clr_am = addr_match_clr | (cmd3 & (state_r == S_AHOLD));
  reg clr_dr;
  reg set_stop;
  reg set_coll;
  reg push;

  // two-entry receive buffer: head sits in the output registers so the
  // receiver may stall for a byte time without losing a word
  always @(posedge clock) begin
    if (!rst_b) begin
      rx_data_r  <= `ITD_BYTE_RST;
      rx_valid_r <= 1'b0;
      e1_data_r  <= `ITD_BYTE_RST;
      e1_valid_r <= 1'b0;
    end else if (rx_pop) begin
      if (e1_valid_r) begin
        rx_data_r <= e1_data_r;
        if (push) begin
          e1_data_r <= sh_r;
        end else begin
          e1_valid_r <= 1'b0;
        end
      end else if (push) begin
        rx_data_r <= sh_r;
      end else begin
        rx_valid_r <= 1'b0;
      end
    end else if (push) begin
      if (!rx_valid_r) begin
        rx_data_r  <= sh_r;
        rx_valid_r <= 1'b1;
      end else begin
        e1_data_r  <= sh_r;
        e1_valid_r <= 1'b1;
      end
    end
  end

  // sticky flags: a set in the same cycle as a clear wins
  always @(posedge clock) begin
    if (!rst_b) begin
      addr_match_flag_r    <= 1'b0;
      data_ready_flag_r    <= 1'b0;
      stop_received_flag_r <= 1'b0;
      collision_seen_r     <= 1'b0;
    end else begin
      addr_match_flag_r    <= set_am | (addr_match_flag_r & ~clr_am);
      data_ready_flag_r    <= set_dr | (data_ready_flag_r & ~clr_dr);
      stop_received_flag_r <= set_stop | (stop_received_flag_r & ~stop_clr);
      collision_seen_r     <= set_coll | (collision_seen_r & ~coll_clr);
    end
  end

  // bus engine
  always @(posedge clock) begin
    // event strobes are registered: flags and buffer act one cycle later
    set_am   <= 1'b0;
    set_dr   <= 1'b0;
    clr_dr   <= 1'b0;
    set_stop <= 1'b0;
    set_coll <= 1'b0;
    push     <= 1'b0;
    if (!rst_b) begin
      state_r    <= S_IDLE;
      cnt_r      <= `ITD_CNT_ZERO;
      sh_r       <= `ITD_BYTE_RST;
      ack_bit_r  <= `ITD_NACK;
      phase_r    <= `ITD_PH_ADDR;
      mode_r     <= 1'b0;
      dir_r      <= 1'b0;
      scl_out_r  <= 1'b0;
      scl_oe_r   <= 1'b0;
      sda_out_r  <= 1'b0;
      sda_oe_r   <= 1'b0;
      tx_ready_r <= 1'b0;
      busy_r     <= 1'b0;
    end else if (!enable) begin
      state_r    <= S_IDLE;
      scl_oe_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      tx_ready_r <= 1'b0;
      busy_r     <= 1'b0;
    end else if (start_c) begin
      // start or repeated start from any state
      state_r    <= S_ADDR;
      cnt_r      <= `ITD_CNT_ZERO;
      scl_oe_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      tx_ready_r <= 1'b0;
      busy_r     <= 1'b1;
    end else if (stop_c) begin
      if (state_r != S_IDLE) begin
        set_stop <= 1'b1;
      end
      state_r    <= S_IDLE;
      scl_oe_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      tx_ready_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      busy_r <= (state_r != S_IDLE);
      case (state_r)
        S_ADDR: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `ITD_BYTE_BITS) begin
            cnt_r <= `ITD_CNT_ZERO;
            if (addr_hit(sh_r, own_addr)) begin
              dir_r   <= sh_r[0];
              mode_r  <= stretch_after_ack_mode;
              phase_r <= `ITD_PH_ADDR;
              if (stretch_after_ack_mode) begin
                // ack goes out by itself; the flag follows the ack bit
                ack_bit_r <= ack_action;
                sda_oe_r  <= ~ack_action;
                state_r   <= S_ACK;
              end else begin
                set_am <= 1'b1;
                scl_oe_r <= 1'b1;
                state_r  <= S_AHOLD;
              end
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_AHOLD: begin
          if (clr_am) begin
            ack_bit_r <= ack_action;
            sda_oe_r  <= ~ack_action;
            scl_oe_r  <= 1'b0;
            state_r   <= S_ACK;
          end
        end
        S_ACK: begin
          if (scl_rise) begin
            cnt_r <= `ITD_ACK_SEEN;
          end else if (scl_fall && cnt_r == `ITD_ACK_SEEN) begin
            cnt_r    <= `ITD_CNT_ZERO;
            sda_oe_r <= 1'b0;
            if (ack_bit_r == `ITD_NACK) begin
              state_r <= S_IDLE;
            end else if (phase_r == `ITD_PH_ADDR) begin
              if (mode_r) begin
                set_am <= 1'b1;
              end
              if (dir_r == `ITD_DIR_READ) begin
                set_dr <= 1'b1;
                scl_oe_r <= 1'b1;
                state_r  <= S_TXW;
              end else if (mode_r) begin
                scl_oe_r <= 1'b1;
                state_r  <= S_POST;
              end else begin
                state_r <= S_RXD;
              end
            end else if (mode_r) begin
              // data flag only after the ack bit in this mode
              set_dr <= 1'b1;
              scl_oe_r <= 1'b1;
              state_r  <= S_RHOLD;
            end else begin
              state_r <= S_RXD;
            end
          end
        end
        S_POST: begin
          // the flag rises a cycle after set_am, so wait for it first
          if (!set_am && (!addr_match_flag_r || clr_am)) begin
            scl_oe_r <= 1'b0;
            state_r  <= S_RXD;
          end
        end
        S_RXD: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `ITD_BYTE_BITS) begin
            cnt_r    <= `ITD_CNT_ZERO;
            scl_oe_r <= 1'b1;
            state_r  <= S_RPUSH;
          end
        end
        S_RPUSH: begin
          // clock stays low while the buffer is full
          if (rx_room) begin
            push <= 1'b1;
            phase_r <= `ITD_PH_DATA;
            if (mode_r) begin
              ack_bit_r <= ack_action;
              sda_oe_r  <= ~ack_action;
              scl_oe_r  <= 1'b0;
              state_r   <= S_ACK;
            end else begin
              set_dr <= 1'b1;
              state_r <= S_RHOLD;
            end
          end
        end
        S_RHOLD: begin
          if (cmd3 || smart_rd) begin
            clr_dr <= 1'b1;
            scl_oe_r <= 1'b0;
            if (mode_r) begin
              state_r <= S_RXD;
            end else begin
              ack_bit_r <= ack_action;
              sda_oe_r  <= ~ack_action;
              state_r   <= S_ACK;
            end
          end
        end
        S_TXW: begin
          // an address flag still pending also holds the first byte
          tx_ready_r <= ~addr_match_flag_r & ~set_am & ~tx_take;
          if (tx_take) begin
            clr_dr <= 1'b1;
            sh_r     <= tx_data;
            sda_oe_r <= ~tx_data[7];
            scl_oe_r <= 1'b0;
            cnt_r    <= `ITD_CNT_ZERO;
            state_r  <= S_TXD;
          end
        end
        S_TXD: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (!sda_oe_r && !sda_s) begin
              // another driver pulled a released bit low
              set_coll <= 1'b1;
              sda_oe_r <= 1'b0;
              scl_oe_r <= 1'b0;
              state_r  <= S_IDLE;
            end
          end else if (scl_fall) begin
            if (cnt_r == `ITD_BYTE_BITS) begin
              sda_oe_r <= 1'b0;
              cnt_r    <= `ITD_CNT_ZERO;
              state_r  <= S_TXACK;
            end else begin
              sh_r     <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            ack_bit_r <= sda_s;
            cnt_r     <= `ITD_ACK_SEEN;
          end else if (scl_fall && cnt_r == `ITD_ACK_SEEN) begin
            cnt_r <= `ITD_CNT_ZERO;
            if (ack_bit_r == `ITD_ACK) begin
              set_dr <= 1'b1;
              scl_oe_r <= 1'b1;
              state_r  <= S_TXW;
            end else begin
              // line stays released for the controller's stop or restart
              state_r <= S_IDLE;
            end
          end
        end
        default: begin
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
          state_r  <= S_IDLE;
        end
      endcase
    end
  end

endmodule

//--- itd_target_assertions.sv
// concurrent checks on the ports of the serial-bus target engine
// assumes one clock domain, synchronous active-low reset, no parameters
`timescale 1ns/100ps
`include "itd_defines.vh"
module itd_target_assertions (
  // clock and reset
  input wire       clock,
  input wire       rst_b,
  // bus drive
  input wire       scl_oe_r,
  input wire       sda_oe_r,
  // configuration and strobes
  input wire       smart_mode_en,
  input wire       stretch_after_ack_mode,
  input wire       ack_action,
  input wire       addr_match_clr,
  input wire       slave_command_wr,
  input wire [1:0] slave_command,
  // streams
  input wire       tx_valid,
  input wire       tx_ready_r,
  input wire       rx_valid_r,
  input wire       rx_ready,
  // status
  input wire       addr_match_flag_r,
  input wire       data_ready_flag_r,
  input wire       stop_received_flag_r,
  input wire       collision_seen_r,
  input wire       dir_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire cmd3 = slave_command_wr && (slave_command == `ITD_CMD_ACK_ACTION);
  wire m0   = !stretch_after_ack_mode;

  AST_HOLD_ADDR: assert property (addr_match_flag_r && $past(addr_match_flag_r) |-> scl_oe_r)
    else $error("clock released while address match pending");
  AST_CLR_ACK: assert property (addr_match_flag_r && addr_match_clr && m0
    |=> !scl_oe_r && sda_oe_r == !$past(ack_action)) else $error("flag clear sent wrong ack");
  AST_CMD3: assert property (cmd3 && addr_match_flag_r && m0
    |=> !addr_match_flag_r && sda_oe_r == !$past(ack_action)) else $error("command 3 mishandled");
  AST_SMART_POP: assert property (smart_mode_en && rx_valid_r && rx_ready && m0
    && data_ready_flag_r && !dir_r |=> !scl_oe_r && sda_oe_r == !$past(ack_action))
    else $error("smart pop sent wrong ack");
  AST_DATA_HOLD: assert property ($rose(data_ready_flag_r) && !dir_r |-> scl_oe_r)
    else $error("clock not held on received byte");
  AST_DIR_MATCH: assert property ($changed(dir_r) |-> ##[0:30] addr_match_flag_r)
    else $error("direction changed without a match");
  AST_COLL_FREE: assert property ($rose(collision_seen_r) |-> ##[0:1]
    (!scl_oe_r && !sda_oe_r && !data_ready_flag_r && !addr_match_flag_r))
    else $error("collision did not release quietly");
  AST_STOP_REL: assert property ($rose(stop_received_flag_r) |-> ##[0:1] (!scl_oe_r && !sda_oe_r))
    else $error("lines driven after stop");
  AST_TX_TAKE: assert property (tx_valid && tx_ready_r |=> !tx_ready_r ##[0:3] !scl_oe_r)
    else $error("transmit byte did not start");
  cover property ($rose(addr_match_flag_r) && dir_r);
  cover property ($rose(stop_received_flag_r));
  cover property ($rose(collision_seen_r));
endmodule

bind itd_target itd_target_assertions u_chk (.clock(clock), .rst_b(rst_b),
  .scl_oe_r(scl_oe_r), .sda_oe_r(sda_oe_r), .smart_mode_en(smart_mode_en),
  .stretch_after_ack_mode(stretch_after_ack_mode), .ack_action(ack_action),
  .addr_match_clr(addr_match_clr), .slave_command_wr(slave_command_wr),
  .slave_command(slave_command), .tx_valid(tx_valid), .tx_ready_r(tx_ready_r),
  .rx_valid_r(rx_valid_r), .rx_ready(rx_ready), .addr_match_flag_r(addr_match_flag_r),
  .data_ready_flag_r(data_ready_flag_r), .stop_received_flag_r(stop_received_flag_r),
  .collision_seen_r(collision_seen_r), .dir_r(dir_r));

//--- itd_master_model.sv
// behavioural bus controller: start, stop, bits and bytes, open drain
// assumes the bench resolves the wires with pull-ups; half bit is 4 clocks
`timescale 1ns/100ps
module itd_master_model (
  // clock
  input  wire clock,
  // bus wires and drive
  input  wire scl,
  input  wire sda,
  output reg  scl_oe,
  output reg  sda_oe,
  // stretch wait ran out
  output reg  to_err
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    to_err = 1'b0;
  end
  task half;
    repeat (4) @(posedge clock);
  endtask
  // a stretching target may hold the clock; the wait is bounded
  task rel_scl;
    integer n;
    begin
      scl_oe <= 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 3000) begin
        @(posedge clock);
        n = n + 1;
      end
      if (n >= 3000) to_err <= 1'b1;
      half;
    end
  endtask
  task start;
    begin
      sda_oe <= 1'b1;
      half;
      scl_oe <= 1'b1;
      half;
    end
  endtask
  task stop;
    begin
      sda_oe <= 1'b1;
      half;
      rel_scl;
      sda_oe <= 1'b0;
      half;
    end
  endtask
  // data moves only while the clock is low, at least one clock after its fall
  task bitx(input b, output r);
    begin
      sda_oe <= ~b;
      half;
      rel_scl;
      r = sda;
      scl_oe <= 1'b1;
      @(posedge clock);
    end
  endtask
  task byte8(input [7:0] d, output [7:0] q);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1) begin
      bitx(d[i], r);
      q[i] = r;
    end
  endtask
endmodule

//--- tb_itd_target.sv
// self-checking bench for the serial-bus target engine
// assumes itd_master_model as controller and pull-ups on both wires
`timescale 1ns/100ps
module tb_itd_target;
  localparam [6:0] ADR = 7'h5B;
  reg clock = 1'b0, rst_b = 1'b0, enable = 1'b1, smart_mode_en = 1'b0;
  reg stretch_after_ack_mode = 1'b0, ack_action = 1'b0;
  reg addr_match_clr = 1'b0, stop_clr = 1'b0, coll_clr = 1'b0;
  reg slave_command_wr = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  reg [1:0] slave_command = 2'h0;
  reg [7:0] tx_data = 8'h00, q;
  reg r;
  integer n_errors = 0, n_tests = 0;
  wire scl_oe_r, sda_oe_r, m_scl, m_sda, m_to, tx_ready_r, rx_valid_r;
  wire am, dr, sr, cs, dir_r, busy;
  wire [7:0] rx_data_r;
  wire scl = !(m_scl | scl_oe_r);
  wire sda = !(m_sda | sda_oe_r);
  initial forever #5 clock = ~clock;
  itd_master_model u_mst (.clock(clock), .scl(scl), .sda(sda), .scl_oe(m_scl),
    .sda_oe(m_sda), .to_err(m_to));
  itd_target u_dut (.clock(clock), .rst_b(rst_b), .scl_in(scl), .scl_out_r(),
    .scl_oe_r(scl_oe_r), .sda_in(sda), .sda_out_r(), .sda_oe_r(sda_oe_r),
    .enable(enable), .smart_mode_en(smart_mode_en), .ack_action(ack_action),
    .stretch_after_ack_mode(stretch_after_ack_mode), .own_addr(ADR),
    .addr_match_clr(addr_match_clr), .stop_clr(stop_clr), .coll_clr(coll_clr),
    .slave_command_wr(slave_command_wr), .slave_command(slave_command),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready_r(tx_ready_r),
    .rx_data_r(rx_data_r), .rx_valid_r(rx_valid_r), .rx_ready(rx_ready),
    .addr_match_flag_r(am), .data_ready_flag_r(dr), .stop_received_flag_r(sr),
    .collision_seen_r(cs), .dir_r(dir_r), .busy_r(busy));
  task complete_run;
    begin
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk1(input got, input exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t bit mismatch", $time);
      end
    end
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t byte %h want %h", $time, got, exp);
      end
    end
  endtask
  task settle;
    begin
      repeat (8) @(posedge clock);
      #1;
    end
  endtask
  // k: bit0 match clear, bit1 stop clear, bit2 collision clear, bit3 command 3
  task sw(input [3:0] k);
    begin
      @(posedge clock);
      {slave_command_wr, coll_clr, stop_clr, addr_match_clr} <= k;
      slave_command <= 2'h3;
      @(posedge clock);
      {slave_command_wr, coll_clr, stop_clr, addr_match_clr} <= 4'h0;
      settle;
    end
  endtask
  task pop;
    begin
      @(posedge clock);
      rx_ready <= 1'b1;
      @(posedge clock);
      rx_ready <= 1'b0;
      settle;
    end
  endtask
  task tx_offer(input [7:0] d);
    integer n;
    begin
      @(posedge clock);
      tx_data <= d;
      tx_valid <= 1'b1;
      n = 0;
      @(posedge clock);
      while (tx_ready_r !== 1'b1 && n < 200) begin
        @(posedge clock);
        n = n + 1;
      end
      tx_valid <= 1'b0;
      if (n >= 200) begin
        n_errors = n_errors + 1;
        complete_run;
      end
    end
  endtask
  task t_mismatch;
    begin
      u_mst.start;
      u_mst.byte8({ADR ^ 7'h01, 1'b1}, q);
      u_mst.bitx(1'b1, r);
      chk1(r, 1'b1);
      chk1(am, 1'b0);
      chk1(dir_r, 1'b0);
      u_mst.stop;
      $display("mismatch done");
    end
  endtask
  task t_write;
    begin
      u_mst.start;
      u_mst.byte8({ADR, 1'b0}, q);
      settle;
      chk1(am & scl_oe_r, 1'b1);
      chk1(dir_r, 1'b0);
      chk1(busy, 1'b1);
      sw(4'h1);
      u_mst.bitx(1'b1, r);
      chk1(r, 1'b0);
      u_mst.byte8(8'hA5, q);
      settle;
      chk1(dr & scl_oe_r, 1'b1);
      chk8(rx_data_r, 8'hA5);
      sw(4'h8);
      u_mst.bitx(1'b1, r);
      chk1(r | dr, 1'b0);
      smart_mode_en <= 1'b1;
      u_mst.byte8(8'h3C, q);
      settle;
      chk1(dr & rx_valid_r, 1'b1);
      pop;
      chk8(rx_data_r, 8'h3C);
      chk1(dr, 1'b0);
      u_mst.bitx(1'b1, r);
      chk1(r, 1'b0);
      smart_mode_en <= 1'b0;
      pop;
      chk1(rx_valid_r, 1'b0);
      u_mst.stop;
      settle;
      chk1(sr, 1'b1);
      chk1(busy, 1'b0);
      sw(4'h2);
      chk1(sr, 1'b0);
      $display("write done");
    end
  endtask
  task t_read(input [7:0] d, input coll);
    begin
      u_mst.start;
      u_mst.byte8({ADR, 1'b1}, q);
      settle;
      chk1(am & dir_r, 1'b1);
      sw(4'h8);
      chk1(am, 1'b0);
      u_mst.bitx(1'b1, r);
      settle;
      chk1(r, 1'b0);
      chk1(dr, 1'b1);
      tx_offer(d);
      u_mst.byte8(coll ? 8'h7F : 8'hFF, q);
      if (!coll) chk8(q, d);
      if (coll) chk1(cs & !scl_oe_r & !dr, 1'b1);
      u_mst.bitx(1'b1, r);
      settle;
      chk1(sda_oe_r | scl_oe_r, 1'b0);
      u_mst.stop;
      sw(4'h4);
      chk1(cs, 1'b0);
      $display("read done");
    end
  endtask
  task t_mode1;
    begin
      stretch_after_ack_mode <= 1'b1;
      u_mst.start;
      u_mst.byte8({ADR, 1'b0}, q);
      u_mst.bitx(1'b1, r);
      settle;
      chk1(r, 1'b0);
      chk1(am & scl_oe_r, 1'b1);
      sw(4'h1);
      u_mst.byte8(8'h5A, q);
      chk1(dr, 1'b0);
      u_mst.bitx(1'b1, r);
      settle;
      chk1(r, 1'b0);
      chk1(dr & scl_oe_r, 1'b1);
      chk8(rx_data_r, 8'h5A);
      sw(4'h8);
      pop;
      ack_action <= 1'b1;
      u_mst.byte8(8'hC3, q);
      u_mst.bitx(1'b1, r);
      chk1(r, 1'b1);
      u_mst.stop;
      $display("mode1 done");
    end
  endtask
  always @(posedge m_to) begin
    n_errors = n_errors + 1;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    settle;
    t_mismatch;
    t_write;
    t_read(8'h96, 1'b0);
    t_read(8'hFF, 1'b1);
    t_mode1;
    complete_run;
  end
endmodule
